// File: design/sfs_pkg.sv
package sfs_pkg;

  // Status word bit positions
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT  = 1;
  localparam int BP_LSB   = 2;
  localparam int BP_MSB   = 4;
  localparam int TB_BIT   = 5;
  localparam int SEC_BIT  = 6;
  localparam int STATUS_LOCK_LO_BIT = 7;
  localparam int STATUS_LOCK_HI_BIT = 8;
  localparam int QE_BIT   = 9;
  localparam int LB_BIT   = 10;
  localparam int DC_BIT   = 11;
  localparam int DRV_LSB  = 12;
  localparam int DRV_MSB  = 13;
  localparam int CMP_BIT  = 14;

  // Factory value of the whole status word
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Bits a status write may change (not busy, latch, spare)
  localparam logic [15:0] WRITE_MASK   = 16'h7FFC;

  // Instruction codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE    = 8'hD8;
  localparam logic [7:0] OP_CE    = 8'hC7;
  localparam logic [7:0] OP_SECE  = 8'h44;
  localparam logic [7:0] OP_SECP  = 8'h42;

  // Read latency choices
  localparam logic [3:0] DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_LONG  = 4'h8;

  // Protection geometry
  localparam int ADDR_W       = 22;
  localparam int SECTOR_SHIFT = 12;
  localparam int HALF_SHIFT   = 15;
  localparam int BLOCK_SHIFT  = 16;
  localparam logic [2:0] SRP_HW   = 3'h1;

  // Internal operation time and its cycle count
  localparam int CLK_KHZ      = 10000;
  localparam int OP_TIME_US   = 50;
  localparam int OP_CYCLES    = OP_TIME_US * CLK_KHZ / 1000;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_DATA   = 4'b0100,
    ST_IGNORE = 4'b1000
  } sfs_state_type;

endpackage : sfs_pkg

// File: design/sfs_prot_if.sv
`timescale 1ns/1ps
interface sfs_prot_if;
  logic [2:0]  bp;
  logic        tb;
  logic        sec;
  logic        cmp;
  logic [21:0] addr;
  logic        hit;

  modport ctl (output bp, output tb, output sec, output cmp,
               output addr, input hit);
  modport dec (input bp, input tb, input sec, input cmp,
               input addr, output hit);
endinterface : sfs_prot_if

// File: design/sfs_protect_decode.sv
`timescale 1ns/1ps
module sfs_protect_decode (
  sfs_prot_if.dec p
);

  logic [22:0] span;
  logic [22:0] addrWide;
  logic        inRange;
  logic        base;

  // Region size from block-protect code and unit select
  always_comb begin
    span = 23'h000000;
    if (p.sec) begin
      if (p.bp >= 3'h4) begin
        span = 23'(1) << sfs_pkg::HALF_SHIFT;
      end else begin
        span = 23'(1) << (sfs_pkg::SECTOR_SHIFT + int'(p.bp) - 1);
      end
    end else begin
      span = 23'(1) << (sfs_pkg::BLOCK_SHIFT + int'(p.bp) - 1);
    end
  end

  // Top or bottom anchoring, then complement
  always_comb begin
    addrWide = {1'b0, p.addr};
    if (p.tb) begin
      inRange = addrWide < span;
    end else begin
      inRange = addrWide >= ((23'(1) << sfs_pkg::ADDR_W) - span);
    end
    if (p.bp == 3'h0) begin
      base = 1'b0;
    end else if (p.bp == 3'h7) begin
      base = 1'b1;
    end else begin
      base = inRange;
    end
    p.hit = base ^ p.cmp;
  end

endmodule : sfs_protect_decode

// File: design/sfs_status_core.sv
`timescale 1ns/1ps
// Function
// - Busy flag at status bit 0 during operations
// - While busy, only status reads accepted
// - Busy clears when the operation ends
// - Write-enable instruction sets latch at bit 1
// - Latch clears at power-up, disable, completions
// - Block-protect field at bits 4..2, zero unprotected
// - Top/bottom select: 0 top, 1 bottom
// - Unit select: 1 sectors, 0 blocks
// - Complement bit 14 inverts protected region
// - Program/erase into protected region rejected
// - Status-lock bits 8..7 pick protection method
// - Lock 00: pin ignored, latch alone gates
// - Lock 01: pin low locks, high allows
// - Lock 10: locked until power cycle, then 00
// - Lock 11: status writes refused forever
// - Pin gates only in standard/dual operation
// - Drive code 00..11 is 100/75/50/25 percent
// - Dummy bit: 4 cycles, or 8 when set
// - Security lock bit 10 one-time settable
// - Quad enable bit 9 repurposes pin functions
// - All status bits factory zero
// - Quad instructions need quad enable set
module sfs_status_core #(
  parameter int OP_CYC = sfs_pkg::OP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        nvInitN,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        si,
  input  wire logic        wpN,
  output logic             so,
  output logic             soOeN,
  output logic             busy,
  output logic [1:0]       driveStrength,
  output logic [3:0]       readDummyCycles,
  output logic             quadEnable,
  output logic             pinFuncEnable,
  output logic             securityLocked,
  output logic             arrayOpStart,
  output logic [7:0]       arrayOpCode,
  output logic [23:0]      arrayOpAddr
);

  localparam logic [15:0] CNT_LOAD = 16'(OP_CYC);

  sfs_prot_if prot ();

  // Pin synchronisers: cs, clock, data, write-protect
  logic [3:0] syncA_q;
  logic [3:0] syncA_d;
  logic [3:0] syncB_q;
  logic [3:0] syncB_d;
  logic       sclkPrev_q;
  logic       sclkPrev_d;
  logic       csPrev_q;
  logic       csPrev_d;

  logic       csS;
  logic       sclkS;
  logic       siS;
  logic       wpS;

  // Frame and status state
  sfs_pkg::sfs_state_type state_q;
  sfs_pkg::sfs_state_type state_d;
  logic [2:0]  bitCnt_q;
  logic [2:0]  bitCnt_d;
  logic [6:0]  shift_q;
  logic [6:0]  shift_d;
  logic [7:0]  opcode_q;
  logic [7:0]  opcode_d;
  logic [2:0]  byteCnt_q;
  logic [2:0]  byteCnt_d;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [15:0] wrVal_q;
  logic [15:0] wrVal_d;
  logic [7:0]  outShift_q;
  logic [7:0]  outShift_d;
  logic [2:0]  outCnt_q;
  logic [2:0]  outCnt_d;
  logic        so_q;
  logic        so_d;
  logic        soOeN_q;
  logic        soOeN_d;
  logic        busy_q;
  logic        busy_d;
  logic        wel_q;
  logic        wel_d;
  logic [15:0] nv_q;
  logic [15:0] nv_d;
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;
  logic        opStart_q;
  logic        opStart_d;
  logic [7:0]  opCode_q;
  logic [7:0]  opCode_d;
  logic [23:0] opAddr_q;
  logic [23:0] opAddr_d;

  // Decoded helpers
  logic        sclkRise;
  logic        sclkFall;
  logic        csFall;
  logic        csRise;
  logic [7:0]  inByte;
  logic [1:0]  srp;
  logic        statusLocked;
  logic        anyProt;
  logic        isAddrOp;
  logic        isRead;
  logic [15:0] status;
  logic        accept;

  assign csS   = syncB_q[3];
  assign sclkS = syncB_q[2];
  assign siS   = syncB_q[1];
  assign wpS   = syncB_q[0];

  // Synchroniser next values
  always_comb begin
    syncA_d    = {csN, sclk, si, wpN};
    syncB_d    = syncA_q;
    sclkPrev_d = sclkS;
    csPrev_d   = csS;
  end

  // Synchroniser registers, idle-high after reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      syncA_q    <= 4'hF;
      syncB_q    <= 4'hF;
      sclkPrev_q <= 1'b1;
      csPrev_q   <= 1'b1;
    end else begin
      syncA_q    <= syncA_d;
      syncB_q    <= syncB_d;
      sclkPrev_q <= sclkPrev_d;
      csPrev_q   <= csPrev_d;
    end
  end

  // Edge and field decode
  always_comb begin
    sclkRise = !csS && sclkS && !sclkPrev_q;
    sclkFall = !csS && !sclkS && sclkPrev_q;
    csFall   = !csS && csPrev_q;
    csRise   = csS && !csPrev_q;
    inByte   = {shift_q, siS};
    srp      = nv_q[sfs_pkg::STATUS_LOCK_HI_BIT:sfs_pkg::STATUS_LOCK_LO_BIT];
    // Pin only counts while its pin is not a quad line
    statusLocked = srp[1]
                 || (srp == 2'(sfs_pkg::SRP_HW)
                     && !nv_q[sfs_pkg::QE_BIT] && !wpS);
    // Chip erase refused if any part is protected
    anyProt = nv_q[sfs_pkg::CMP_BIT]
            ? (nv_q[sfs_pkg::BP_MSB:sfs_pkg::BP_LSB] != 3'h7)
            : (nv_q[sfs_pkg::BP_MSB:sfs_pkg::BP_LSB] != 3'h0);
    isAddrOp = (inByte == sfs_pkg::OP_PP) || (inByte == sfs_pkg::OP_QPP)
            || (inByte == sfs_pkg::OP_SE) || (inByte == sfs_pkg::OP_BE)
            || (inByte == sfs_pkg::OP_BE32)
            || (inByte == sfs_pkg::OP_SECE)
            || (inByte == sfs_pkg::OP_SECP);
    isRead = (inByte == sfs_pkg::OP_RDSR1)
          || (inByte == sfs_pkg::OP_RDSR2);
    status = nv_q;
    status[sfs_pkg::BUSY_BIT] = busy_q;
    status[sfs_pkg::WEL_BIT]  = wel_q;
  end

  // Protection lookup for the captured address
  assign prot.bp   = nv_q[sfs_pkg::BP_MSB:sfs_pkg::BP_LSB];
  assign prot.tb   = nv_q[sfs_pkg::TB_BIT];
  assign prot.sec  = nv_q[sfs_pkg::SEC_BIT];
  assign prot.cmp  = nv_q[sfs_pkg::CMP_BIT];
  assign prot.addr = addr_q[21:0];

  sfs_protect_decode u_decode (
    .p (prot.dec)
  );

  // Acceptance of the instruction closed by the cs rise
  always_comb begin
    accept = 1'b0;
    if (state_q != sfs_pkg::ST_IGNORE && bitCnt_q == 3'h0
        && wel_q) begin
      unique case (opcode_q)
        sfs_pkg::OP_WRSR:
          accept = byteCnt_q != 3'h0 && !statusLocked;
        sfs_pkg::OP_PP, sfs_pkg::OP_SE, sfs_pkg::OP_BE,
        sfs_pkg::OP_BE32:
          accept = byteCnt_q >= 3'h3 && !prot.hit;
        sfs_pkg::OP_QPP:
          accept = byteCnt_q >= 3'h3 && !prot.hit
                && nv_q[sfs_pkg::QE_BIT];
        sfs_pkg::OP_CE:
          accept = byteCnt_q == 3'h0 && !anyProt;
        sfs_pkg::OP_SECE, sfs_pkg::OP_SECP:
          accept = byteCnt_q >= 3'h3
                && !nv_q[sfs_pkg::LB_BIT];
        default:
          accept = 1'b0;
      endcase
    end
  end

  // Instruction shifter, status output and operation control
  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    shift_d    = shift_q;
    opcode_d   = opcode_q;
    byteCnt_d  = byteCnt_q;
    addr_d     = addr_q;
    wrVal_d    = wrVal_q;
    outShift_d = outShift_q;
    outCnt_d   = outCnt_q;
    so_d       = so_q;
    soOeN_d    = 1'b1;
    busy_d     = busy_q;
    wel_d      = wel_q;
    nv_d       = nv_q;
    busyCnt_d  = busyCnt_q;
    opStart_d  = 1'b0;
    opCode_d   = opCode_q;
    opAddr_d   = opAddr_q;

    // Pin stays driven only while a status read streams out
    if (!csS && state_q == sfs_pkg::ST_DATA
        && (opcode_q == sfs_pkg::OP_RDSR1
            || opcode_q == sfs_pkg::OP_RDSR2)) begin
      soOeN_d = soOeN_q;
    end

    if (csFall) begin
      state_d   = sfs_pkg::ST_OPCODE;
      bitCnt_d  = 3'h0;
      byteCnt_d = 3'h0;
      wrVal_d   = nv_q;
    end else if (sclkRise) begin
      shift_d  = inByte[6:0];
      bitCnt_d = bitCnt_q + 3'h1;
      if (bitCnt_q == 3'h7) begin
        unique case (state_q)
          sfs_pkg::ST_OPCODE: begin
            opcode_d = inByte;
            outCnt_d = 3'h0;
            outShift_d = (inByte == sfs_pkg::OP_RDSR2)
                       ? status[15:8] : status[7:0];
            if (busy_q && !isRead) begin
              state_d = sfs_pkg::ST_IGNORE;
            end else if (isAddrOp) begin
              state_d = sfs_pkg::ST_ADDR;
            end else begin
              state_d = sfs_pkg::ST_DATA;
            end
          end
          sfs_pkg::ST_ADDR: begin
            addr_d    = {addr_q[15:0], inByte};
            byteCnt_d = byteCnt_q + 3'h1;
            if (byteCnt_q == 3'h2) begin
              state_d = sfs_pkg::ST_DATA;
            end
          end
          sfs_pkg::ST_DATA: begin
            if (byteCnt_q == 3'h0) begin
              wrVal_d[7:0] = inByte;
            end else if (byteCnt_q == 3'h1) begin
              wrVal_d[15:8] = inByte;
            end
            if (byteCnt_q != 3'h7) begin
              byteCnt_d = byteCnt_q + 3'h1;
            end
          end
          sfs_pkg::ST_IGNORE: begin
            state_d = sfs_pkg::ST_IGNORE;
          end
        endcase
      end
    end else if (sclkFall && soOeN_d == 1'b1
                 && state_q == sfs_pkg::ST_DATA
                 && (opcode_q == sfs_pkg::OP_RDSR1
                     || opcode_q == sfs_pkg::OP_RDSR2)) begin
      soOeN_d = 1'b0;
    end

    // Status bits shift out on falling clock edges
    if (sclkFall && soOeN_d == 1'b0) begin
      so_d       = outShift_q[7];
      outShift_d = {outShift_q[6:0], 1'b0};
      outCnt_d   = outCnt_q + 3'h1;
      if (outCnt_q == 3'h7) begin
        outShift_d = (opcode_q == sfs_pkg::OP_RDSR2)
                   ? status[15:8] : status[7:0];
      end
    end

    // Simple latch instructions act at the frame end
    if (csRise && state_q != sfs_pkg::ST_IGNORE
        && bitCnt_q == 3'h0) begin
      if (opcode_q == sfs_pkg::OP_WREN) begin
        wel_d = 1'b1;
      end else if (opcode_q == sfs_pkg::OP_WRDI) begin
        wel_d = 1'b0;
      end
    end

    // Accepted write: start the busy period
    if (csRise && accept) begin
      busy_d    = 1'b1;
      busyCnt_d = CNT_LOAD;
      opStart_d = 1'b1;
      opCode_d  = opcode_q;
      opAddr_d  = addr_q;
      if (opcode_q == sfs_pkg::OP_WRSR) begin
        // Read-only positions are masked off
        nv_d = (wrVal_q & sfs_pkg::WRITE_MASK)
             | (nv_q & ~sfs_pkg::WRITE_MASK);
        // Lock bit can only rise
        nv_d[sfs_pkg::LB_BIT] = wrVal_q[sfs_pkg::LB_BIT]
                              | nv_q[sfs_pkg::LB_BIT];
      end
    end

    // Operation end releases busy and the latch
    if (busy_q) begin
      busyCnt_d = busyCnt_q - 16'h0001;
      if (busyCnt_q <= 16'h0001) begin
        busy_d    = 1'b0;
        wel_d     = 1'b0;
        busyCnt_d = 16'h0000;
      end
    end

    if (csS) begin
      soOeN_d = 1'b1;
    end
  end

  // Register stage; power cycle keeps stored bits except lock-down
  always_ff @(posedge clk_sys) begin
    if (!nvInitN) begin
      nv_q <= sfs_pkg::STATUS_RESET;
    end else if (!nrst) begin
      if (nv_q[sfs_pkg::STATUS_LOCK_HI_BIT:sfs_pkg::STATUS_LOCK_LO_BIT] == 2'b10) begin
        nv_q[sfs_pkg::STATUS_LOCK_HI_BIT:sfs_pkg::STATUS_LOCK_LO_BIT] <= 2'b00;
      end
    end else begin
      nv_q <= nv_d;
    end
    if (!nrst || !nvInitN) begin
      state_q    <= sfs_pkg::ST_IGNORE;
      bitCnt_q   <= 3'h0;
      shift_q    <= 7'h00;
      opcode_q   <= 8'h00;
      byteCnt_q  <= 3'h0;
      addr_q     <= 24'h000000;
      wrVal_q    <= sfs_pkg::STATUS_RESET;
      outShift_q <= 8'h00;
      outCnt_q   <= 3'h0;
      so_q       <= 1'b0;
      soOeN_q    <= 1'b1;
      busy_q     <= 1'b0;
      wel_q      <= 1'b0;
      busyCnt_q  <= 16'h0000;
      opStart_q  <= 1'b0;
      opCode_q   <= 8'h00;
      opAddr_q   <= 24'h000000;
    end else begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      opcode_q   <= opcode_d;
      byteCnt_q  <= byteCnt_d;
      addr_q     <= addr_d;
      wrVal_q    <= wrVal_d;
      outShift_q <= outShift_d;
      outCnt_q   <= outCnt_d;
      so_q       <= so_d;
      soOeN_q    <= soOeN_d;
      busy_q     <= busy_d;
      wel_q      <= wel_d;
      busyCnt_q  <= busyCnt_d;
      opStart_q  <= opStart_d;
      opCode_q   <= opCode_d;
      opAddr_q   <= opAddr_d;
    end
  end

  // Configuration outputs straight from stored bits
  assign so              = so_q;
  assign soOeN           = soOeN_q;
  assign busy            = busy_q;
  // Drive code passes through unchanged
  assign driveStrength   = nv_q[sfs_pkg::DRV_MSB:sfs_pkg::DRV_LSB];
  assign readDummyCycles = nv_q[sfs_pkg::DC_BIT]
                         ? sfs_pkg::DUMMY_LONG : sfs_pkg::DUMMY_SHORT;
  assign quadEnable      = nv_q[sfs_pkg::QE_BIT];
  assign pinFuncEnable   = !nv_q[sfs_pkg::QE_BIT];
  assign securityLocked  = nv_q[sfs_pkg::LB_BIT];
  assign arrayOpStart    = opStart_q;
  assign arrayOpCode     = opCode_q;
  assign arrayOpAddr     = opAddr_q;

endmodule : sfs_status_core

// File: dv/sfs_status_properties.sv
`timescale 1ns/1ps
module sfs_status_checker #(
  parameter int OP_CYC = sfs_pkg::OP_CYCLES
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       nvInitN,
  input wire logic       busy,
  input wire logic [1:0] driveStrength,
  input wire logic [3:0] readDummyCycles,
  input wire logic       quadEnable,
  input wire logic       pinFuncEnable,
  input wire logic       securityLocked,
  input wire logic       arrayOpStart
);
  logic [15:0] busyLen_q;
  logic [15:0] busyLen_d;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Length of the current busy span, cleared when idle
  always_comb busyLen_d = busy ? busyLen_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_sys) busyLen_q <= nrst ? busyLen_d : 16'h0000;

  pulse_once_a: assert property (
    arrayOpStart |=> !arrayOpStart) else $error("start pulse too long");
  start_busy_a: assert property (
    arrayOpStart |-> ##[0:1] busy) else $error("start without busy");
  busy_cause_a: assert property (
    $rose(busy) |-> arrayOpStart || $past(arrayOpStart))
    else $error("busy without start");
  // One cycle of slack either side of the nominal operation time
  busy_length_a: assert property (
    $fell(busy) |-> busyLen_q >= OP_CYC - 1 && busyLen_q <= OP_CYC + 1)
    else $error("busy span off");
  busy_bound_a: assert property (
    busyLen_q <= OP_CYC + 1) else $error("busy never ends");
  busy_blocks_a: assert property (
    $past(busy, 2) && busy |-> !arrayOpStart)
    else $error("operation started while busy");
  pin_func_a: assert property (
    pinFuncEnable == !quadEnable) else $error("pin function mismatch");
  dummy_code_a: assert property (
    readDummyCycles == sfs_pkg::DUMMY_SHORT ||
    readDummyCycles == sfs_pkg::DUMMY_LONG) else $error("bad dummy count");
  lock_sticky_a: assert property (
    disable iff (!nrst || !nvInitN) !$fell(securityLocked))
    else $error("security lock cleared");
  cfg_change_a: assert property (
    $changed({driveStrength, quadEnable, securityLocked, readDummyCycles})
    |-> ##[0:1] busy) else $error("config changed outside a write");

  cover property (arrayOpStart);
  cover property ($fell(busy));
  cover property ($rose(securityLocked));
endmodule : sfs_status_checker

bind sfs_status_core sfs_status_checker #(.OP_CYC(OP_CYC)) u_checker (
  .clk_sys, .nrst, .nvInitN, .busy, .driveStrength, .readDummyCycles,
  .quadEnable, .pinFuncEnable, .securityLocked, .arrayOpStart);

// File: dv/sfs_spi_host.sv
`timescale 1ns/1ps
module sfs_spi_host (
  input  wire logic clk_sys,
  output logic      csN,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  // Idle bus: deselected, serial clock parked low
  initial begin
    csN  = 1'h1;
    sclk = 1'h0;
    si   = 1'h0;
  end

  // Half of the 800 ns serial period, moving just after a system edge
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : half

  // One frame of whole bytes, MSB first; the last byte is read back
  task automatic xfer(input logic [7:0] b[$], output logic [7:0] rx);
    rx = 8'h00;
    half();
    csN = 1'h0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        si = b[i][k];
        half();
        sclk = 1'h1;
        rx   = {rx[6:0], so};
        half();
        sclk = 1'h0;
      end
    end
    half();
    csN = 1'h1;
    // Released line shows the inverse so no stale bit looks valid
    si = ~si;
    half();
  endtask : xfer
endmodule : sfs_spi_host

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  op;
    logic [23:0] a;
    logic        ok;
  } sfs_row_type;
  logic        clk_sys, nrst, nvInitN, wpN, csN, sclk, si, so, soOeN;
  logic        busy, quadEnable, pinFuncEnable, securityLocked, arrayOpStart;
  logic [1:0]  driveStrength;
  logic [3:0]  readDummyCycles;
  logic [7:0]  arrayOpCode, rx;
  logic [23:0] arrayOpAddr;
  logic [7:0]  q[$];
  int          n_fail, num_checks, nStart, n0;
  // Protect settings, operation and whether the array accepts it
  sfs_row_type tab [14] = '{
    {8'h04, 8'h00, sfs_pkg::OP_PP,   24'h3F0000, 1'h0},
    {8'h04, 8'h00, sfs_pkg::OP_PP,   24'h3EFFFF, 1'h1},
    {8'h24, 8'h00, sfs_pkg::OP_SE,   24'h00F000, 1'h0},
    {8'h24, 8'h00, sfs_pkg::OP_SE,   24'h3F0000, 1'h1},
    {8'h44, 8'h00, sfs_pkg::OP_SE,   24'h3FF000, 1'h0},
    {8'h44, 8'h00, sfs_pkg::OP_SE,   24'h3FE000, 1'h1},
    {8'h04, 8'h40, sfs_pkg::OP_SE,   24'h3F0000, 1'h1},
    {8'h04, 8'h40, sfs_pkg::OP_SE,   24'h000000, 1'h0},
    {8'h00, 8'h00, sfs_pkg::OP_QPP,  24'h000000, 1'h0},
    {8'h00, 8'h02, sfs_pkg::OP_QPP,  24'h000100, 1'h1},
    {8'h1C, 8'h00, sfs_pkg::OP_BE,   24'h100000, 1'h0},
    {8'h00, 8'h00, sfs_pkg::OP_BE32, 24'h200000, 1'h1},
    {8'h00, 8'h00, sfs_pkg::OP_CE,   24'h000000, 1'h1},
    {8'h00, 8'h00, sfs_pkg::OP_SECP, 24'h001000, 1'h1}};

  sfs_status_core u_dut (.clk_sys, .nrst, .nvInitN, .csN, .sclk, .si, .wpN,
    .so, .soOeN, .busy, .driveStrength, .readDummyCycles, .quadEnable,
    .pinFuncEnable, .securityLocked, .arrayOpStart, .arrayOpCode,
    .arrayOpAddr);
  sfs_spi_host u_host (.clk_sys, .csN, .sclk, .si, .so);

  // 10 MHz system clock
  initial clk_sys = 1'h0;
  always #50 clk_sys = ~clk_sys;

  // Accepted operations seen at the array side
  always @(posedge clk_sys) if (arrayOpStart === 1'h1) nStart++;

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pwr(input logic init);
    nrst    = 1'h0;
    nvInitN = init;
    repeat (5) @(posedge clk_sys);
    #1;
    nrst    = 1'h1;
    nvInitN = 1'h1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : pwr

  task automatic send(input logic [7:0] b[$]);
    u_host.xfer(b, rx);
  endtask : send

  task automatic rdc(input logic [7:0] op, input logic [7:0] exp);
    u_host.xfer('{op, 8'h00}, rx);
    chk({8'h00, rx}, {8'h00, exp});
  endtask : rdc

  // Bounded wait so a stuck busy flag cannot hang the run
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'h0 && k < 2000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      $display("[FAIL] %0t busy stuck", $time);
    end
  endtask : idle

  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
    send('{sfs_pkg::OP_WREN});
    send('{sfs_pkg::OP_WRSR, lo, hi});
    idle();
  endtask : wrsr

  initial begin
    #9000000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    {nrst, nvInitN, wpN} = 3'h1;
    {n_fail, num_checks, nStart} = '0;
    pwr(1'h0);
    chk({6'h00, busy, soOeN, quadEnable, securityLocked, driveStrength,
         readDummyCycles}, 16'h0104);
    rdc(sfs_pkg::OP_RDSR1, 8'h00);
    rdc(sfs_pkg::OP_RDSR2, 8'h00);
    send('{sfs_pkg::OP_WREN});
    rdc(sfs_pkg::OP_RDSR1, 8'h02);
    send('{sfs_pkg::OP_WRDI});
    rdc(sfs_pkg::OP_RDSR1, 8'h00);
    send('{sfs_pkg::OP_WRSR, 8'h1C, 8'h00});
    rdc(sfs_pkg::OP_RDSR1, 8'h00);
    // Every drive code, with ones written into the busy and latch bits
    for (int d = 0; d < 4; d++) begin
      wrsr(8'h03, {2'h0, d[1:0], 4'h8});
      chk({14'h0, driveStrength}, 16'(d));
      chk({12'h0, readDummyCycles}, {12'h0, sfs_pkg::DUMMY_LONG});
      rdc(sfs_pkg::OP_RDSR1, 8'h00);
    end
    wrsr(8'h00, 8'h00);
    send('{sfs_pkg::OP_WREN});
    send('{sfs_pkg::OP_PP, 8'h00, 8'h00, 8'h00, 8'hA5});
    chk({15'h0, busy}, 16'h0001);
    rdc(sfs_pkg::OP_RDSR1, 8'h03);
    send('{sfs_pkg::OP_WRSR, 8'h1C, 8'h00});
    idle();
    rdc(sfs_pkg::OP_RDSR1, 8'h00);
    foreach (tab[i]) begin
      wrsr(tab[i].lo, tab[i].hi);
      send('{sfs_pkg::OP_WREN});
      q = '{tab[i].op, tab[i].a[23:16], tab[i].a[15:8], tab[i].a[7:0]};
      if (tab[i].op == sfs_pkg::OP_CE) q = '{tab[i].op};
      if (tab[i].op inside {sfs_pkg::OP_PP, sfs_pkg::OP_QPP, sfs_pkg::OP_SECP})
        q.push_back(8'hA5);
      n0 = nStart;
      send(q);
      chk(16'(nStart - n0), {15'h0, tab[i].ok});
      if (tab[i].ok) chk({8'h00, arrayOpCode}, {8'h00, tab[i].op});
      if (tab[i].ok && tab[i].op != sfs_pkg::OP_CE)
        chk(arrayOpAddr[23:8], tab[i].a[23:8]);
      idle();
      rdc(sfs_pkg::OP_RDSR1, tab[i].lo | {6'h00, !tab[i].ok, 1'h0});
    end
    wrsr(8'h80, 8'h00);
    wpN = 1'h0;
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR1, 8'h82);
    wpN = 1'h1;
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR1, 8'h00);
    // Quad set only because the protect pin is driven, not tied
    wrsr(8'h80, 8'h02);
    chk({14'h0, quadEnable, pinFuncEnable}, 16'h0002);
    wpN = 1'h0;
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR2, 8'h00);
    chk({14'h0, quadEnable, pinFuncEnable}, 16'h0001);
    wpN = 1'h1;
    wrsr(8'h00, 8'h09);
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR2, 8'h09);
    pwr(1'h1);
    rdc(sfs_pkg::OP_RDSR2, 8'h08);
    wrsr(8'h00, 8'h04);
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR2, 8'h04);
    wrsr(8'h80, 8'h05);
    wrsr(8'h00, 8'h00);
    rdc(sfs_pkg::OP_RDSR2, 8'h05);
    pwr(1'h1);
    rdc(sfs_pkg::OP_RDSR2, 8'h05);
    chk({15'h0, securityLocked}, 16'h0001);
    conclude();
  end
endmodule : tb_top
